// [core/cdo_consts.svh]
// Opcode fields, widths and constant values for the complement/decrement unit
`ifndef CDO_CONSTS_SVH
`define CDO_CONSTS_SVH
`define CDO_OP_HI 11
`define CDO_OP_LO 6
`define CDO_DEST_BIT 5
`define CDO_ADDR_HI 4
`define CDO_ADDR_LO 0
`define CDO_OPC_CPL 6'h09
`define CDO_OPC_DECF 6'h03
`define CDO_OPC_DSZ 6'h0b
`define CDO_BYTE_ZERO 8'h00
`define CDO_BYTE_ONE 8'h01
`define CDO_ADDR_ZERO 5'h00
`endif

// [core/cdo_pkg.sv]
// Types shared by the complement/decrement unit
package cdo_pkg;
   typedef logic [11:0] cdo_instr_t;
   typedef logic [7:0] cdo_byte_t;
   typedef logic [4:0] cdo_addr_t;
   typedef enum logic [1:0] {
      CDO_RUN = 2'h1,
      CDO_FLUSH = 2'h2
   } cdo_state_e;
   // Result write carried to the register file and working register
   typedef struct packed {
      logic to_file;
      logic to_w;
      cdo_addr_t addr;
      cdo_byte_t data;
   } cdo_wr_s;
endpackage : cdo_pkg

// [core/cdo_exec.sv]
// Execute stage for complement, decrement and decrement-skip-if-zero
// Notes on behaviour
// - Complement op inverts file byte, destination bit picks W or file.
// - Decrement op subtracts one, routed by destination bit, updates zero.
// - Decrement-skip op subtracts one, routes like decrement, no flags.
// - Skip op with zero result drops prefetched word; two cycles.
`include "cdo_consts.svh"
module cdo_exec (
   input wire logic clock,
   input wire logic rstn,
   input wire cdo_pkg::cdo_instr_t instr,
   input wire logic instr_valid,
   input wire cdo_pkg::cdo_byte_t file_rdata,
   output cdo_pkg::cdo_addr_t file_raddr,
   output cdo_pkg::cdo_wr_s wr,
   output logic zero_we,
   output logic zero_flag,
   output logic flush,
   output logic busy
);
   import cdo_pkg::*;

   // ************************************************
   // Reset release
   // ************************************************
   logic rst_s1_r;
   logic rst_s2_r;
   // Two stages so release never lands near a clock edge
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   logic rst_n;
   assign rst_n = rst_s2_r;

   // ************************************************
   // Decode and compute
   // ************************************************
   logic [5:0] opc;
   logic is_cpl;
   logic is_decf;
   logic is_dsz;
   logic dest_f;
   cdo_byte_t result;
   cdo_state_e state_r;
   cdo_state_e state_nxt;
   logic take;

   // Prefetched word in the flush slot is ignored, executes as a no-op
   assign take = instr_valid && (state_r == CDO_RUN);
   assign opc = instr[`CDO_OP_HI:`CDO_OP_LO];
   assign dest_f = instr[`CDO_DEST_BIT];
   assign is_cpl = take && (opc == `CDO_OPC_CPL);
   assign is_decf = take && (opc == `CDO_OPC_DECF);
   assign is_dsz = take && (opc == `CDO_OPC_DSZ);
   assign file_raddr = instr[`CDO_ADDR_HI:`CDO_ADDR_LO];

   // Combinational read of the file port, so one cycle per op, two for a skip with a zero result
   always_comb begin
      if (is_cpl) begin
         result = ~file_rdata;
      end else begin
         // Both decrement flavours share one subtractor
         result = file_rdata - `CDO_BYTE_ONE;
      end
   end

   // ************************************************
   // Result and flag registers
   // ************************************************
   cdo_wr_s wr_r;
   cdo_wr_s wr_nxt;
   logic zwe_r;
   logic zwe_nxt;
   logic zf_r;
   logic zf_nxt;
   logic flush_r;
   logic flush_nxt;

   // Next write, flag and flush values
   always_comb begin
      wr_nxt = '0;
      zwe_nxt = 1'b0;
      zf_nxt = zf_r;
      flush_nxt = 1'b0;
      state_nxt = CDO_RUN;
      if (is_cpl || is_decf || is_dsz) begin
         wr_nxt.to_file = dest_f;
         wr_nxt.to_w = !dest_f;
         wr_nxt.addr = file_raddr;
         wr_nxt.data = result;
      end
      // Flag write kept off the skip op on purpose
      if (is_cpl || is_decf) begin
         zwe_nxt = 1'b1;
         zf_nxt = (result == `CDO_BYTE_ZERO);
      end
      // Skip variant leaves the flag alone
      if (is_dsz && (result == `CDO_BYTE_ZERO)) begin
         flush_nxt = 1'b1;
         state_nxt = CDO_FLUSH;
      end
      case (state_r)
         CDO_RUN: ;
         CDO_FLUSH: ;
         default: state_nxt = CDO_RUN;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_r <= '0;
         zwe_r <= 1'b0;
         zf_r <= 1'b0;
         flush_r <= 1'b0;
         state_r <= CDO_RUN;
      end else begin
         wr_r <= wr_nxt;
         zwe_r <= zwe_nxt;
         zf_r <= zf_nxt;
         flush_r <= flush_nxt;
         state_r <= state_nxt;
      end
   end

   logic busy_r;
   // Busy marks the no-op slot of a taken skip
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= (state_nxt == CDO_FLUSH);
      end
   end

   assign wr = wr_r;
   assign zero_we = zwe_r;
   assign zero_flag = zf_r;
   assign flush = flush_r;
   assign busy = busy_r;

   // ************************************************
   // Checks
   // ************************************************
   property p_cpl_inv;
      @(posedge clock) disable iff (!rst_n)
      is_cpl |=> (wr.data == ~$past(file_rdata)) && zero_we;
   endproperty
   a_cpl_inv: assert property (p_cpl_inv)
      else $error("complement result wrong");

   property p_decf;
      @(posedge clock) disable iff (!rst_n)
      is_decf |=> wr.data == $past(file_rdata) - `CDO_BYTE_ONE;
   endproperty
   a_decf: assert property (p_decf)
      else $error("decrement result wrong");

   property p_dest;
      @(posedge clock) disable iff (!rst_n)
      (is_decf && !dest_f) |=> wr.to_w && !wr.to_file;
   endproperty
   a_dest: assert property (p_dest)
      else $error("destination routing wrong");

   property p_dsz_noflag;
      @(posedge clock) disable iff (!rst_n)
      is_dsz |=> !zero_we && $stable(zero_flag);
   endproperty
   a_dsz_noflag: assert property (p_dsz_noflag)
      else $error("skip op touched flag");

   sequence s_dsz_zero;
      is_dsz && (file_rdata == `CDO_BYTE_ONE);
   endsequence
   sequence s_flush_slot;
      flush && busy ##1 !flush && !busy;
   endsequence
   property p_skip;
      @(posedge clock) disable iff (!rst_n)
      s_dsz_zero |=> s_flush_slot;
   endproperty
   a_skip: assert property (p_skip)
      else $error("skip did not flush one slot");

   property p_noskip;
      @(posedge clock) disable iff (!rst_n)
      (is_dsz && file_rdata != `CDO_BYTE_ONE) |=> !flush;
   endproperty
   a_noskip: assert property (p_noskip)
      else $error("flush on nonzero result");

   property p_zero;
      @(posedge clock) disable iff (!rst_n)
      zero_we |-> zero_flag == (wr.data == `CDO_BYTE_ZERO);
   endproperty
   a_zero: assert property (p_zero)
      else $error("zero flag mismatch");

   // Complement result lands where the destination bit points
   property p_cpl_dest;
      @(posedge clock) disable iff (!rst_n)
      is_cpl |=> (wr.to_file == $past(dest_f)) &&
         (wr.to_w == !$past(dest_f));
   endproperty
   a_cpl_dest: assert property (p_cpl_dest)
      else $error("complement routing wrong");

   // Plain decrement never costs a second cycle
   property p_decf_one;
      @(posedge clock) disable iff (!rst_n)
      is_decf |=> !flush && !busy;
   endproperty
   a_decf_one: assert property (p_decf_one)
      else $error("decrement took a second cycle");

   // Skip op still writes its decremented byte
   property p_dsz_data;
      @(posedge clock) disable iff (!rst_n)
      is_dsz |=> wr.data == $past(file_rdata) - `CDO_BYTE_ONE;
   endproperty
   a_dsz_data: assert property (p_dsz_data)
      else $error("skip op result wrong");

   // The dropped word must leave no trace on the outputs
   property p_slot_quiet;
      @(posedge clock) disable iff (!rst_n)
      (state_r == CDO_FLUSH) |=> !wr.to_file && !wr.to_w && !zero_we;
   endproperty
   a_slot_quiet: assert property (p_slot_quiet)
      else $error("no-op slot wrote a result");

   // Flag only moves on a cycle that writes it
   property p_zero_hold;
      @(posedge clock) disable iff (!rst_n)
      !zero_we |-> $stable(zero_flag);
   endproperty
   a_zero_hold: assert property (p_zero_hold)
      else $error("zero flag moved without a write");
endmodule : cdo_exec

// [bench/cdo_exec_tb.sv]
// Self-checking bench for the complement/decrement execute unit
`include "cdo_consts.svh"
module complement_decrement_ops_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import cdo_pkg::*;
   // ****************************************
   // Signals and instance
   // ****************************************
   logic clock = 1'b0;
   logic rstn = 1'b0;
   cdo_instr_t instr = 12'h000;
   logic instr_valid = 1'b0;
   cdo_byte_t file_rdata = 8'h00;
   cdo_addr_t file_raddr;
   cdo_wr_s wr;
   logic zero_we;
   logic zero_flag;
   logic flush;
   logic busy;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   // 4 ns period
   always #2 clock = ~clock;
   cdo_exec dut (.clock(clock), .rstn(rstn), .instr(instr),
      .instr_valid(instr_valid), .file_rdata(file_rdata),
      .file_raddr(file_raddr), .wr(wr), .zero_we(zero_we),
      .zero_flag(zero_flag), .flush(flush), .busy(busy));
   // Watchdog, far above the few dozen cycles the run needs
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         failures = failures + 1;
         close_out();
      end
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(string name, logic [14:0] seen, logic [14:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Present one word; hold keeps a follow-up word valid in the next slot
   task automatic issue(logic [5:0] opc, logic d, cdo_addr_t f,
      cdo_byte_t v, logic hold);
      @(posedge clock);
      instr <= {opc, d, f};
      instr_valid <= 1'b1;
      file_rdata <= v;
      #1 check("file_raddr", 15'(file_raddr), 15'(f));
      @(posedge clock);
      instr <= {`CDO_OPC_CPL, 1'b1, f};
      instr_valid <= hold;
      #1;
   endtask : issue
   task automatic exp_out(logic d, cdo_addr_t f, cdo_byte_t dat, logic zw,
      logic zf, logic fl);
      check("wr", wr, {d, ~d, f, dat});
      check("flags", 15'({zero_we, zero_flag, flush, busy}),
         15'({zw, zf, fl, fl}));
   endtask : exp_out
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_cpl();
      issue(`CDO_OPC_CPL, 1'b0, 5'h13, 8'h13, 1'b0);
      exp_out(1'b0, 5'h13, 8'hec, 1'b1, 1'b0, 1'b0);
      issue(`CDO_OPC_CPL, 1'b1, 5'h1f, 8'hff, 1'b0);
      exp_out(1'b1, 5'h1f, 8'h00, 1'b1, 1'b1, 1'b0);
   endtask : t_cpl
   task automatic t_decf();
      issue(`CDO_OPC_DECF, 1'b1, 5'h01, 8'h01, 1'b0);
      exp_out(1'b1, 5'h01, 8'h00, 1'b1, 1'b1, 1'b0);
      issue(`CDO_OPC_DECF, 1'b0, 5'h00, 8'h00, 1'b0);
      exp_out(1'b0, 5'h00, 8'hff, 1'b1, 1'b0, 1'b0);
   endtask : t_decf
   // Zero flag is 0 here, so a wrong flag write on a zero result shows
   task automatic t_dsz();
      issue(`CDO_OPC_DSZ, 1'b0, 5'h0a, 8'h05, 1'b0);
      exp_out(1'b0, 5'h0a, 8'h04, 1'b0, 1'b0, 1'b0);
      issue(`CDO_OPC_DSZ, 1'b1, 5'h15, 8'h01, 1'b1);
      exp_out(1'b1, 5'h15, 8'h00, 1'b0, 1'b0, 1'b1);
      @(posedge clock);
      instr_valid <= 1'b0;
      #1 check("slot",
         15'({wr.to_file, wr.to_w, zero_we, flush, busy}), 15'h0);
   endtask : t_dsz
   // A neighbouring opcode must leave the file and W writes, the flag write and flush quiet
   task automatic t_other();
      issue(6'h0a, 1'b1, 5'h02, 8'h7f, 1'b0);
      check("quiet",
         15'({wr.to_file, wr.to_w, zero_we, flush}), 15'h0);
   endtask : t_other
   task automatic close_out();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   // Main sequence
   initial begin
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      t_cpl();
      t_decf();
      t_dsz();
      t_other();
      close_out();
   end
endmodule : complement_decrement_ops_tb
